// File: flow_pkg.sv
// constants, opcodes and flag layout of the branch and flag control block
// assumes nothing of its surroundings
package flow_pkg;

  // flag register layout, bits 7 and 6 always read as ones
  typedef struct packed {
    logic one7;
    logic one6;
    logic halfCarry;
    logic irqMask;
    logic negative;
    logic zero;
    logic overflow;
    logic carry;
  } flag_register_t;

  typedef struct packed {
    logic [15:0] addr;
    logic addrOe;
    logic rw;
    logic rwOe;
    logic memoryCycleValid;
  } bus_drive_t;

  localparam logic [7:0] FLAGS_RESET = 8'hD0;
  localparam logic [7:0] FLAGS_FIXED = 8'hC0;
  localparam logic [15:0] PC_RESET = 16'h0000;

  localparam logic [3:0] BRANCH_GROUP = 4'h2;
  localparam logic [7:0] OP_NO_OPERATION = 8'h01;
  localparam logic [7:0] OP_HALT_UNTIL_INTERRUPT = 8'h3E;
  localparam logic [7:0] OP_INTERRUPT_RETURN = 8'h3B;
  localparam logic [7:0] OP_CLEAR_CARRY = 8'h00;
  localparam logic [7:0] OP_SET_CARRY = 8'h0D;
  localparam logic [7:0] OP_CLEAR_OVERFLOW = 8'h0A;
  localparam logic [7:0] OP_SET_OVERFLOW = 8'h0B;
  localparam logic [7:0] OP_CLEAR_IRQ_MASK = 8'h0E;
  localparam logic [7:0] OP_SET_IRQ_MASK = 8'h0F;
  localparam logic [7:0] OP_ACCUM_TO_FLAGS = 8'h06;
  localparam logic [7:0] OP_FLAGS_TO_ACCUM = 8'h07;

  // cycles per instruction and the operand fetch cycle, opcode fetch counted as cycle 1
  localparam logic [3:0] CYC_BRANCH = 4'h4;
  localparam logic [3:0] CYC_SHORT = 4'h2;
  localparam logic [3:0] CYC_HALT = 4'h9;
  localparam logic [3:0] CYC_RETURN = 4'hA;
  localparam logic [3:0] CYC_OPERAND = 4'h2;

  localparam logic [15:0] LEN_ONE = 16'h0001;
  localparam logic [15:0] LEN_BRANCH = 16'h0002;

endpackage

// File: branch_test.sv
// condition evaluation for the relative branch group
// assumes a flag register value and the branch opcode's low nibble
`timescale 1ns/10ps
module branch_test (
  input wire logic [3:0] condCode,
  input wire flow_pkg::flag_register_t flags,
  output logic taken
);

  wire logic signedLess = flags.negative ^ flags.overflow;
  logic rawTest;

  // even codes branch on a clear test, odd codes on a set test
  always_comb begin
    unique case (condCode[3:1])
      3'h0: rawTest = 1'b0;
      3'h1: rawTest = flags.carry | flags.zero;
      3'h2: rawTest = flags.carry;
      3'h3: rawTest = flags.zero;
      3'h4: rawTest = flags.overflow;
      3'h5: rawTest = flags.negative;
      3'h6: rawTest = signedLess;
      3'h7: rawTest = flags.zero | signedLess;
    endcase
  end

  assign taken = rawTest ^ ~condCode[0];

endmodule // branch_test

// File: branch_and_flag_control.sv
// program flow and flag manipulation execution unit
// assumes memory and accumulator logic share mclk; interrupt pins are async
// Function
// - carry branches 24/25: two bytes, four cycles, taken on carry 0/1
// - 27 branches on zero set, 26 on zero clear; flags untouched
// - 22 branches when carry or zero is 0, 23 when it is 1
// - 28 branches on overflow clear, two bytes, four cycles
// - 29 branches on overflow set, no flag changes
// - no operation 01: one byte, two cycles, only advances counter
// - halt 3E, nine cycles, then bus floated and valid line low
// - 00,0D,0A,0B,0E,0F clear or set carry, overflow, mask alone
// - accumulator-to-flags loads flag bits 5 to 0 from accumulator A; bits 7 and 6 stay one
// - interrupt return restores flag bits 5 to 0 from stack; bits 7 and 6 stay one
// - interrupt sets mask; masked wait ends only by non-maskable
`timescale 1ns/10ps
module branch_and_flag_control #(
  parameter int ADDR_W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] dataIn,
  output logic [15:0] addrOut,
  output logic addrOe,
  output logic rwOut,
  output logic rwOe,
  output logic [7:0] dataOut,
  output logic dataOe,
  output logic memoryCycleValid,
  input wire logic irqPin,
  input wire logic nmiPin,
  input wire logic [7:0] accumA,
  input wire logic [7:0] stackedFlags,
  output logic [7:0] accumOut,
  output logic accumLoad,
  output logic interruptTaken,
  output logic unknownOpcode,
  output flow_pkg::flag_register_t flags,
  output logic [15:0] pc
);

  if (ADDR_W != 16) begin : g_addr_check
    $error("branch_and_flag_control serves a 16-bit address only");
  end

  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b10
  } state_t;

  state_t state;
  state_t next_state;
  logic [3:0] cyc;
  logic [3:0] next_cyc;
  logic [7:0] opcode;
  logic [7:0] offset;
  logic [15:0] next_pc;
  flow_pkg::flag_register_t next_flags;
  flow_pkg::bus_drive_t next_bus;
  logic irqMeta, irqSync, nmiMeta, nmiSync;

  // interrupt pins pass two flops before use
  always_ff @(posedge mclk) begin
    if (rst) begin
      irqMeta <= 1'b0;
      irqSync <= 1'b0;
      nmiMeta <= 1'b0;
      nmiSync <= 1'b0;
    end else begin
      irqMeta <= irqPin;
      irqSync <= irqMeta;
      nmiMeta <= nmiPin;
      nmiSync <= nmiMeta;
    end
  end

  // decode
  wire logic isBranch = opcode[7:4] == flow_pkg::BRANCH_GROUP;
  wire logic isHalt = opcode == flow_pkg::OP_HALT_UNTIL_INTERRUPT;
  wire logic isReturn = opcode == flow_pkg::OP_INTERRUPT_RETURN;
  wire logic isNop = opcode == flow_pkg::OP_NO_OPERATION;
  wire logic isTap = opcode == flow_pkg::OP_ACCUM_TO_FLAGS;
  wire logic isTpa = opcode == flow_pkg::OP_FLAGS_TO_ACCUM;
  wire logic isFlagOp = opcode == flow_pkg::OP_CLEAR_CARRY
    || opcode == flow_pkg::OP_SET_CARRY
    || opcode == flow_pkg::OP_CLEAR_OVERFLOW
    || opcode == flow_pkg::OP_SET_OVERFLOW
    || opcode == flow_pkg::OP_CLEAR_IRQ_MASK
    || opcode == flow_pkg::OP_SET_IRQ_MASK;
  wire logic isKnown = isBranch | isHalt | isReturn | isNop | isTap
    | isTpa | isFlagOp;
  wire logic [3:0] lastCyc = isBranch ? flow_pkg::CYC_BRANCH
    : isHalt ? flow_pkg::CYC_HALT
    : isReturn ? flow_pkg::CYC_RETURN
    : flow_pkg::CYC_SHORT;
  wire logic execEnd = state == ST_EXEC && cyc == lastCyc;

  logic branchTaken;
  branch_test u_test (
    .condCode(opcode[3:0]),
    .flags(flags),
    .taken(branchTaken)
  );

  // signed offset added to the address after the two-byte branch
  wire logic [15:0] offsetExt = {{8{offset[7]}}, offset};
  wire logic [15:0] branchNext = pc + flow_pkg::LEN_BRANCH
    + (branchTaken ? offsetExt : 16'h0000);
  wire logic wakeUp = nmiSync | (irqSync & ~flags.irqMask);

  always_comb begin
    next_state = state;
    next_cyc = cyc + 4'h1;
    next_pc = pc;
    unique case (state)
      ST_FETCH: begin
        next_state = ST_EXEC;
      end
      ST_EXEC: begin
        if (execEnd) begin
          next_cyc = 4'h1;
          next_state = isHalt ? ST_WAIT : ST_FETCH;
          next_pc = isBranch ? branchNext : pc + flow_pkg::LEN_ONE;
        end
      end
      ST_WAIT: begin
        next_cyc = 4'h1;
        if (wakeUp) begin
          next_state = ST_FETCH;
        end
      end
      default: begin
        next_state = ST_FETCH;
        next_cyc = 4'h1;
      end
    endcase
  end

  // flag updates happen at the last cycle of their instruction, and irqMask is also set on wake from wait
  always_comb begin
    next_flags = flags;
    if (execEnd) begin
      unique case (1'b1)
        opcode == flow_pkg::OP_CLEAR_CARRY: next_flags.carry = 1'b0;
        opcode == flow_pkg::OP_SET_CARRY: next_flags.carry = 1'b1;
        opcode == flow_pkg::OP_CLEAR_OVERFLOW:
          next_flags.overflow = 1'b0;
        opcode == flow_pkg::OP_SET_OVERFLOW:
          next_flags.overflow = 1'b1;
        opcode == flow_pkg::OP_CLEAR_IRQ_MASK:
          next_flags.irqMask = 1'b0;
        opcode == flow_pkg::OP_SET_IRQ_MASK:
          next_flags.irqMask = 1'b1;
        isTap: next_flags = accumA;
        isReturn: next_flags = stackedFlags;
        default: next_flags = flags;
      endcase
    end else if (state == ST_WAIT && wakeUp) begin
      next_flags.irqMask = 1'b1;
    end
    next_flags = next_flags | flow_pkg::FLAGS_FIXED;
  end

  // bus drive for the cycle about to begin
  wire logic nextIsOperand = next_state == ST_EXEC
    && next_cyc == flow_pkg::CYC_OPERAND;
  always_comb begin
    next_bus.addr = next_pc + flow_pkg::LEN_ONE;
    next_bus.addrOe = 1'b1;
    next_bus.rw = 1'b1;
    next_bus.rwOe = 1'b1;
    next_bus.memoryCycleValid = 1'b0;
    if (next_state == ST_FETCH) begin
      next_bus.addr = next_pc;
      next_bus.memoryCycleValid = 1'b1;
    end else if (nextIsOperand) begin
      next_bus.memoryCycleValid = 1'b1;
    end else if (next_state == ST_WAIT) begin
      next_bus.addrOe = 1'b0;
      next_bus.rwOe = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= ST_FETCH;
      cyc <= 4'h1;
      pc <= flow_pkg::PC_RESET;
      flags <= flow_pkg::FLAGS_RESET;
      opcode <= flow_pkg::OP_NO_OPERATION;
      offset <= 8'h00;
    end else begin
      state <= next_state;
      cyc <= next_cyc;
      pc <= next_pc;
      flags <= next_flags;
      if (state == ST_FETCH) begin
        opcode <= dataIn;
      end
      if (state == ST_EXEC && cyc == flow_pkg::CYC_OPERAND) begin
        offset <= dataIn;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      addrOut <= flow_pkg::PC_RESET;
      addrOe <= 1'b1;
      rwOut <= 1'b1;
      rwOe <= 1'b1;
      memoryCycleValid <= 1'b1;
      dataOut <= 8'h00;
      dataOe <= 1'b0;
      accumOut <= 8'h00;
      accumLoad <= 1'b0;
      interruptTaken <= 1'b0;
      unknownOpcode <= 1'b0;
    end else begin
      addrOut <= next_bus.addr;
      addrOe <= next_bus.addrOe;
      rwOut <= next_bus.rw;
      rwOe <= next_bus.rwOe;
      memoryCycleValid <= next_bus.memoryCycleValid;
      dataOut <= 8'h00;
      dataOe <= 1'b0;
      accumLoad <= execEnd & isTpa;
      if (execEnd && isTpa) begin
        accumOut <= flags;
      end
      interruptTaken <= state == ST_WAIT && wakeUp;
      unknownOpcode <= execEnd & ~isKnown;
    end
  end

endmodule // branch_and_flag_control

// File: flow_properties.sv
// port assertions for the branch and flag control unit
// assumes one clock mclk and a synchronous reset rst
`timescale 1ns/10ps
module flow_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] dataIn,
  input wire logic [15:0] addrOut,
  input wire logic addrOe,
  input wire logic rwOe,
  input wire logic dataOe,
  input wire logic memoryCycleValid,
  input wire logic interruptTaken,
  input wire logic [7:0] accumA,
  input wire flow_pkg::flag_register_t flags,
  input wire logic [15:0] pc
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire fetch = memoryCycleValid && addrOe && addrOut == pc;
  wire isBranch = fetch && dataIn[7:4] == 4'h2;
  wire cz = flags.carry || flags.zero;
  wire skip = fetch && (dataIn == 8'h24 && flags.carry
    || dataIn == 8'h25 && !flags.carry || dataIn == 8'h26 && flags.zero
    || dataIn == 8'h27 && !flags.zero || dataIn == 8'h22 && cz
    || dataIn == 8'h23 && !cz || dataIn == 8'h28 && flags.overflow
    || dataIn == 8'h29 && !flags.overflow);
  bus_quiet_a: assert property (!addrOe |-> !memoryCycleValid && !rwOe
    && !dataOe) else $error("bus not quiet");
  fixed_bits_a: assert property (flags.one7 && flags.one6)
    else $error("fixed bits low");
  branch_form_a: assert property (isBranch |=> memoryCycleValid
    && addrOut == $past(pc) + 16'h0001 ##1 !memoryCycleValid [*2] ##1 fetch)
    else $error("branch cycle form");
  branch_flags_a: assert property (isBranch |-> ##4
    flags == $past(flags, 4)) else $error("branch changed flags");
  branch_target_a: assert property (isBranch |-> ##4
    pc == $past(pc, 4) + 16'h0002 || pc == $past(pc, 4) + 16'h0002
    + {{8{$past(dataIn[7], 3)}}, $past(dataIn, 3)}) else $error("target");
  branch_skip_a: assert property (skip |-> ##4
    pc == $past(pc, 4) + 16'h0002) else $error("branch wrongly taken");
  noop_step_a: assert property (fetch && dataIn == 8'h01 |-> ##2
    pc == $past(pc, 2) + 16'h0001 && flags == $past(flags, 2))
    else $error("no-op effect");
  carry_set_a: assert property (fetch && dataIn == 8'h0D |-> ##2
    flags == ($past(flags, 2) | 8'h01)) else $error("set carry");
  overflow_clear_a: assert property (fetch && dataIn == 8'h0A |->
    ##2 flags == ($past(flags, 2) & 8'hFD)) else $error("clear overflow");
  accum_load_a: assert property (fetch && dataIn == 8'h06 |-> ##2
    flags == ($past(accumA) | 8'hC0)) else $error("accum to flags");
  halt_float_a: assert property (fetch && dataIn == 8'h3E |-> ##9
    !addrOe && !memoryCycleValid) else $error("halt did not float");
  wake_mask_a: assert property (interruptTaken |-> flags.irqMask)
    else $error("wake left mask clear");
endmodule // flow_properties

// File: mem_model.sv
// zero-wait memory answering the unit's fetches
// assumes the bench loads bytes into mem directly
`timescale 1ns/10ps
module mem_model (
  input wire logic mclk,
  input wire logic [15:0] addrOut,
  input wire logic addrOe,
  input wire logic memoryCycleValid,
  output logic [7:0] dataIn
);
  logic [7:0] mem [0:65535];
  logic [7:0] lastVal = 8'h00;
  wire sel = addrOe && memoryCycleValid;
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'h01;
  // unselected bus shows the inverse of the last byte, not a stale copy
  assign dataIn = sel ? mem[addrOut] : ~lastVal;
  always @(posedge mclk) if (sel) lastVal <= mem[addrOut];
endmodule // mem_model

// File: tb_branch_and_flag_control.sv
// bench running a short program through the flow unit
// assumes mem_model as memory and flow_properties bound to the unit
`timescale 1ns/10ps
module tb_branch_and_flag_control;
  logic mclk = 1'b0, rst = 1'b1, irqPin = 1'b0, nmiPin = 1'b0;
  logic [7:0] accumA = 8'h00, stackedFlags = 8'h00, dataIn, dataOut, accumOut;
  logic [15:0] addrOut, pc, expPc = 16'h0000;
  logic addrOe, rwOut, rwOe, dataOe, memoryCycleValid;
  logic accumLoad, interruptTaken, unknownOpcode;
  flow_pkg::flag_register_t flags;
  int num_errors = 0, checks_done = 0, k;
  always #50 mclk = ~mclk;
  branch_and_flag_control #(.ADDR_W(16)) u_dut (.mclk(mclk), .rst(rst),
    .dataIn(dataIn), .addrOut(addrOut), .addrOe(addrOe), .rwOut(rwOut),
    .rwOe(rwOe), .dataOut(dataOut), .dataOe(dataOe), .irqPin(irqPin),
    .memoryCycleValid(memoryCycleValid), .nmiPin(nmiPin), .accumA(accumA),
    .stackedFlags(stackedFlags), .accumOut(accumOut), .accumLoad(accumLoad),
    .interruptTaken(interruptTaken), .unknownOpcode(unknownOpcode),
    .flags(flags), .pc(pc));
  mem_model u_mem (.mclk(mclk), .addrOut(addrOut), .addrOe(addrOe),
    .memoryCycleValid(memoryCycleValid), .dataIn(dataIn));
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask
  task automatic ins(logic [7:0] op, logic [7:0] off, int n,
    logic [15:0] npc, logic [7:0] f);
    u_mem.mem[expPc] = op;
    u_mem.mem[expPc + 16'h0001] = off;
    repeat (n) @(posedge mclk);
    #1;
    chk("pc", npc, pc);
    chk("flags", {8'h00, f}, {8'h00, flags});
    expPc = npc;
  endtask
  task summarize;
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    #1;
    ins(8'h0D, 8'h00, 2, 16'h0001, 8'hD1);
    ins(8'h24, 8'h10, 4, 16'h0003, 8'hD1);
    ins(8'h25, 8'h04, 4, 16'h0009, 8'hD1);
    ins(8'h00, 8'h00, 2, 16'h000A, 8'hD0);
    ins(8'h24, 8'hF8, 4, 16'h0004, 8'hD0);
    ins(8'h0B, 8'h00, 2, 16'h0005, 8'hD2);
    ins(8'h28, 8'h05, 4, 16'h0007, 8'hD2);
    ins(8'h29, 8'h10, 4, 16'h0019, 8'hD2);
    accumA <= 8'h04;
    ins(8'h06, 8'h00, 2, 16'h001A, 8'hC4);
    ins(8'h26, 8'h10, 4, 16'h001C, 8'hC4);
    ins(8'h27, 8'h10, 4, 16'h002E, 8'hC4);
    ins(8'h22, 8'h10, 4, 16'h0030, 8'hC4);
    ins(8'h23, 8'h20, 4, 16'h0052, 8'hC4);
    ins(8'h01, 8'h00, 2, 16'h0053, 8'hC4);
    ins(8'h07, 8'h00, 2, 16'h0054, 8'hC4);
    chk("accumLoad", 16'h0001, {15'h0000, accumLoad});
    chk("accumOut", 16'h00C4, {8'h00, accumOut});
    ins(8'h0F, 8'h00, 2, 16'h0055, 8'hD4);
    ins(8'h0E, 8'h00, 2, 16'h0056, 8'hC4);
    accumA <= 8'hFF;
    ins(8'h06, 8'h00, 2, 16'h0057, 8'hFF);
    ins(8'h0A, 8'h00, 2, 16'h0058, 8'hFD);
    ins(8'h00, 8'h00, 2, 16'h0059, 8'hFC);
    ins(8'h3E, 8'h00, 9, 16'h005A, 8'hFC);
    chk("float", 16'h0000, {12'h000, addrOe, rwOe, dataOe,
      memoryCycleValid});
    irqPin <= 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    chk("masked wait", 16'h0000, {15'h0000, memoryCycleValid});
    nmiPin <= 1'b1;
    k = 0;
    while (interruptTaken !== 1'b1 && k < 10) begin
      @(posedge mclk);
      #1;
      k++;
    end
    chk("wake", 16'h0001, {15'h0000, interruptTaken});
    chk("mask", 16'h0001, {15'h0000, flags.irqMask});
    chk("refetch", expPc, addrOut);
    nmiPin <= 1'b0;
    stackedFlags <= 8'h0B;
    ins(8'h3B, 8'h00, 10, 16'h005B, 8'hCB);
    ins(8'h2D, 8'h10, 4, 16'h005D, 8'hCB);
    ins(8'h2C, 8'h10, 4, 16'h006F, 8'hCB);
    ins(8'h2B, 8'hF0, 4, 16'h0061, 8'hCB);
    ins(8'h20, 8'h04, 4, 16'h0067, 8'hCB);
    ins(8'h4F, 8'h00, 2, 16'h0068, 8'hCB);
    chk("unknownOpcode", 16'h0001, {15'h0000, unknownOpcode});
    chk("rwOut dataOut", 16'h0100, {7'h00, rwOut, dataOut});
    ins(8'h3E, 8'h00, 9, 16'h0069, 8'hCB);
    @(posedge mclk);
    #1;
    chk("irq wake", 16'h0001, {15'h0000, interruptTaken});
    chk("wake flags", 16'h00DB, {8'h00, flags});
    summarize();
  end
endmodule // tb_branch_and_flag_control
bind branch_and_flag_control flow_properties u_props (.mclk(mclk),
  .rst(rst), .dataIn(dataIn), .addrOut(addrOut), .addrOe(addrOe),
  .rwOe(rwOe), .dataOe(dataOe), .memoryCycleValid(memoryCycleValid),
  .interruptTaken(interruptTaken), .accumA(accumA), .flags(flags),
  .pc(pc));
